// ===== inc/rhc_reg_map.vh
// register map, field positions and encodings of the reference/home/compare block
// Function
// R1: every configuration field resets to zero, all options disabled.
// R2: right switch going inactive latches actual position when enabled.
// R3: right switch going active latches actual position when enabled.
// R4: left switch also acts as home reference when enabled.
// R5: right switch also acts as home reference when enabled.
// R6: home mode 0 uses next encoder index pulse as home event.
// R7: modes 2, 4, 6: high reference; home at rise, fall or middle.
// R8: modes 9, 11, 13: low reference; home at middle, rise or fall.
// R9: modes 3 and 12 treat the opposite level as negative-side region.
// R10: armed home tracking stores home position, raises done event; clearing it disarms.
// R11: zero-at-goal resets actual position at target and restarts the ramp.
// R12: position wrap confines actual position to minus range .. range minus one.
// R13: encoder wrap confines encoder position to minus range .. range minus one.
// R14: goal pin source picks goal, speed, encoder fault or compare flag.
// R15: compare source picks actual or encoder position.
// R16: compare operand picks compare, home, latched or revolution count.
// R17: stop polarity applied before edge detection; zero means active low.
// R18: left switch going inactive latches actual position when enabled.
// R19: reserved bits 26, 27, 30 ignored on write and read as zero.
// R20: inputs synchronised first; one capture at most per qualifying edge.
`ifndef RHC_REG_MAP_VH
`define RHC_REG_MAP_VH
// ------------------------------------------------------------
// register indices (byte address = 4 x index)
// ------------------------------------------------------------
`define RHC_IDX_STATUS   6'h00
`define RHC_IDX_REFCONF  6'h01
`define RHC_IDX_ACTUAL   6'h02
`define RHC_IDX_TARGET   6'h03
`define RHC_IDX_RANGE    6'h04
`define RHC_IDX_COMPARE  6'h05
`define RHC_IDX_LATCHED  6'h06
`define RHC_IDX_HOME     6'h07
`define RHC_IDX_ENCPOS   6'h08
`define RHC_IDX_ENCLATCH 6'h09
// ------------------------------------------------------------
// reference_switch_config fields
// ------------------------------------------------------------
`define RHC_REFCONF_RST  32'h00000000
`define RHC_REFCONF_WMSK 32'hb3ffffff
`define RHC_B_POL_L      2
`define RHC_B_POL_R      3
`define RHC_B_LAT_INACT_L 10
`define RHC_B_LAT_ACT_L  11
`define RHC_B_LAT_INACT_R 12
`define RHC_B_LAT_ACT_R  13
`define RHC_B_L_HOME     14
`define RHC_B_R_HOME     15
`define RHC_F_HMODE_HI   19
`define RHC_F_HMODE_LO   16
`define RHC_B_HOME_ARM   20
`define RHC_B_ZERO_GOAL  21
`define RHC_B_POS_WRAP   22
`define RHC_F_GSEL_HI    24
`define RHC_F_GSEL_LO    23
`define RHC_B_CMP_SRC    25
`define RHC_F_CMPOP_HI   29
`define RHC_F_CMPOP_LO   28
`define RHC_B_ENC_WRAP   31
// ------------------------------------------------------------
// home event codes
// ------------------------------------------------------------
`define RHC_HM_INDEX     4'h0
`define RHC_HM_HI_RISE   4'h2
`define RHC_HM_HI_NEG    4'h3
`define RHC_HM_HI_FALL   4'h4
`define RHC_HM_HI_MID    4'h6
`define RHC_HM_LO_MID    4'h9
`define RHC_HM_LO_RISE   4'hb
`define RHC_HM_LO_NEG    4'hc
`define RHC_HM_LO_FALL   4'hd
// ------------------------------------------------------------
// status bits and bus answers
// ------------------------------------------------------------
`define RHC_S_DONE       0
`define RHC_S_GOAL       1
`define RHC_S_CMP        2
`define RHC_S_HOMEACT    3
`define RHC_RESP_OKAY    2'h0
`define RHC_RESP_SLVERR  2'h2
`endif

// ===== core/rhc_sync.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module rhc_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule // rhc_sync

// ===== core/rhc_ref_switch.v
// reference switch, home tracking, wrap and position compare logic with axi4-lite registers
`timescale 1ns/1ps
`include "rhc_reg_map.vh"
module rhc_ref_switch #(
    parameter ADDR_W = 8
) (
    input  wire              clk_sys,
    input  wire              rst_n,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              left_stop_input,
    input  wire              right_stop_input,
    input  wire              home_reference_input,
    input  wire              enc_a,
    input  wire              enc_b,
    input  wire              enc_n,
    input  wire              step_pulse,
    input  wire              step_dir,
    input  wire              positioning_mode,
    input  wire              speed_attained_flag,
    input  wire              encoder_fault_flag,
    input  wire [31:0]       revolution_count,
    output reg               goal_arrival_output,
    output reg               ramp_restart,
    output reg               compare_match_flag
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    wire [5:0] pin_s;

    rhc_sync #(.WIDTH(6)) u_sync ( // R20
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .pin_in   ({enc_n, enc_b, enc_a, home_reference_input,
                    right_stop_input, left_stop_input}),
        .sync_out (pin_s)
    );

    reg  [31:0] cfg_q;
    reg  [31:0] actual_position_q;
    reg  [31:0] target_position_q;
    reg  [31:0] circular_range_q;
    reg  [31:0] compare_position_q;
    reg  [31:0] latched_position_q;
    reg  [31:0] home_position_q;
    reg  [31:0] encoder_position_q;
    reg  [31:0] encoder_latched_q;
    reg  [31:0] home_entry_q;
    reg         capture_done_q;
    reg  [5:0]  pin_prev_q;
    reg         stop_l_act_q;
    reg         stop_r_act_q;
    reg         home_act_q;

    // ------------------------------------------------------------
    // one step with optional circular wrap
    // ------------------------------------------------------------
    function [31:0] step_wrap;
        input [31:0] pos;
        input        up;
        input        wrap_en;
        input [31:0] range;
        reg   [31:0] nxt;
        begin
            nxt = up ? pos + 32'h00000001 : pos - 32'h00000001;
            step_wrap = nxt;
            if (wrap_en) begin
                if (up && (pos == range - 32'h00000001))
                    step_wrap = 32'h00000000 - range;
                else if (!up && (pos == 32'h00000000 - range))
                    step_wrap = range - 32'h00000001;
            end
        end
    endfunction

    function [31:0] byte_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            byte_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i])
                    byte_merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // switch polarity and edges
    // ------------------------------------------------------------
    wire stop_l_act = cfg_q[`RHC_B_POL_L] ? pin_s[0] : ~pin_s[0]; // R17
    wire stop_r_act = cfg_q[`RHC_B_POL_R] ? pin_s[1] : ~pin_s[1]; // R17
    wire l_went_act   = stop_l_act & ~stop_l_act_q;
    wire l_went_inact = ~stop_l_act & stop_l_act_q;
    wire r_went_act   = stop_r_act & ~stop_r_act_q;
    wire r_went_inact = ~stop_r_act & stop_r_act_q;

    // one capture per cycle even when several edges coincide
    wire stop_capture = (l_went_inact & cfg_q[`RHC_B_LAT_INACT_L])  // R18
                      | (l_went_act   & cfg_q[`RHC_B_LAT_ACT_L])
                      | (r_went_inact & cfg_q[`RHC_B_LAT_INACT_R])  // R2
                      | (r_went_act   & cfg_q[`RHC_B_LAT_ACT_R]);   // R3 R20

    // ------------------------------------------------------------
    // home event decode
    // ------------------------------------------------------------
    wire [3:0] hmode = cfg_q[`RHC_F_HMODE_HI:`RHC_F_HMODE_LO];
    wire       ref_raw = pin_s[2]
                       | (cfg_q[`RHC_B_L_HOME] & stop_l_act)  // R4
                       | (cfg_q[`RHC_B_R_HOME] & stop_r_act); // R5
    wire       hm_high = (hmode == `RHC_HM_HI_RISE) | (hmode == `RHC_HM_HI_NEG)
                       | (hmode == `RHC_HM_HI_FALL) | (hmode == `RHC_HM_HI_MID);
    wire       hm_low  = (hmode == `RHC_HM_LO_MID)  | (hmode == `RHC_HM_LO_RISE)
                       | (hmode == `RHC_HM_LO_NEG)  | (hmode == `RHC_HM_LO_FALL);
    // a home-flagged switch counts in its active sense
    wire       home_act = hm_low ? ~ref_raw : ref_raw; // R7 R8
    wire       h_enter  = home_act & ~home_act_q;
    wire       h_leave  = ~home_act & home_act_q;
    wire       index_ev = pin_s[5] & ~pin_prev_q[5];
    wire       hm_entry = (hmode == `RHC_HM_HI_RISE) | (hmode == `RHC_HM_LO_RISE)
                        | (hmode == `RHC_HM_HI_NEG)  | (hmode == `RHC_HM_LO_NEG); // R9
    wire       hm_exit  = (hmode == `RHC_HM_HI_FALL) | (hmode == `RHC_HM_LO_FALL);
    wire       hm_mid   = (hmode == `RHC_HM_HI_MID)  | (hmode == `RHC_HM_LO_MID);
    reg        home_event;
    reg [31:0] home_value;
    wire [32:0] mid_sum = {home_entry_q[31], home_entry_q}
                        + {actual_position_q[31], actual_position_q};

    always @* begin
        home_event = 1'b0;
        home_value = actual_position_q;
        if (hmode == `RHC_HM_INDEX) begin
            home_event = index_ev; // R6
        end else if (hm_entry) begin
            home_event = h_enter; // R7 R8 R9
        end else if (hm_exit) begin
            home_event = h_leave; // R7 R8
        end else if (hm_mid) begin
            home_event = h_leave; // R7 R8
            home_value = mid_sum[32:1];
        end
    end

    // ------------------------------------------------------------
    // quadrature decode
    // ------------------------------------------------------------
    wire enc_step = pin_s[3] ^ pin_prev_q[3] ^ pin_s[4] ^ pin_prev_q[4];
    wire enc_up   = pin_s[3] ^ pin_prev_q[4];

    // ------------------------------------------------------------
    // axi4-lite handshakes
    // ------------------------------------------------------------
    reg  [ADDR_W-1:0] awaddr_q;
    reg  [31:0]       wdata_q;
    reg  [3:0]        wstrb_q;
    reg               aw_hold_q;
    reg               w_hold_q;
    wire              wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire              aw_hold_d = (aw_hold_q & ~wr_fire) | (s_axi_awvalid & s_axi_awready);
    wire              w_hold_d  = (w_hold_q & ~wr_fire) | (s_axi_wvalid & s_axi_wready);
    wire              bvalid_d  = wr_fire | (s_axi_bvalid & ~s_axi_bready);
    wire              rd_fire   = s_axi_arvalid & s_axi_arready;
    wire              rvalid_d  = rd_fire | (s_axi_rvalid & ~s_axi_rready);
    wire [5:0]        wr_idx = awaddr_q[7:2];
    wire [5:0]        rd_idx = s_axi_araddr[7:2];
    wire              wr_mapped = (wr_idx <= `RHC_IDX_ENCLATCH);
    wire              rd_mapped = (rd_idx <= `RHC_IDX_ENCLATCH);

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= {ADDR_W{1'b0}};
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RHC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RHC_RESP_OKAY;
        end else begin
            aw_hold_q     <= aw_hold_d;
            w_hold_q      <= w_hold_d;
            s_axi_awready <= ~aw_hold_d & ~bvalid_d;
            s_axi_wready  <= ~w_hold_d & ~bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (s_axi_awvalid && s_axi_awready)
                awaddr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
                s_axi_bresp <= wr_mapped ? `RHC_RESP_OKAY : `RHC_RESP_SLVERR;
            if (rd_fire)
                s_axi_rresp <= rd_mapped ? `RHC_RESP_OKAY : `RHC_RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [31:0] status_word = {28'h0000000, home_act_q, compare_match_flag,
                               goal_flag, capture_done_q};
    reg  [31:0] rd_word;

    always @* begin
        case (rd_idx)
            `RHC_IDX_STATUS:   rd_word = status_word;
            `RHC_IDX_REFCONF:  rd_word = cfg_q & `RHC_REFCONF_WMSK; // R19
            `RHC_IDX_ACTUAL:   rd_word = actual_position_q;
            `RHC_IDX_TARGET:   rd_word = target_position_q;
            `RHC_IDX_RANGE:    rd_word = circular_range_q;
            `RHC_IDX_COMPARE:  rd_word = compare_position_q;
            `RHC_IDX_LATCHED:  rd_word = latched_position_q;
            `RHC_IDX_HOME:     rd_word = home_position_q;
            `RHC_IDX_ENCPOS:   rd_word = encoder_position_q;
            `RHC_IDX_ENCLATCH: rd_word = encoder_latched_q;
            default:           rd_word = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_n)
            s_axi_rdata <= 32'h00000000;
        else if (rd_fire)
            s_axi_rdata <= rd_word;
    end

    // ------------------------------------------------------------
    // configuration, positions and events
    // ------------------------------------------------------------
    wire        wr_cfg   = wr_fire & (wr_idx == `RHC_IDX_REFCONF);
    wire        wr_stat  = wr_fire & (wr_idx == `RHC_IDX_STATUS);
    wire        wr_act   = wr_fire & (wr_idx == `RHC_IDX_ACTUAL);
    wire [31:0] wmerged  = byte_merge(32'h00000000, wdata_q, wstrb_q);
    // set wins over a same-cycle clear
    wire        done_set = cfg_q[`RHC_B_HOME_ARM] & home_event; // R10
    wire        done_clr = wr_stat & wmerged[`RHC_S_DONE] & capture_done_q;
    wire        goal_flag = positioning_mode & (actual_position_q == target_position_q);
    wire        zero_now  = goal_flag & cfg_q[`RHC_B_ZERO_GOAL] & ~wr_act; // R11
    wire [31:0] cfg_new   = byte_merge(cfg_q, wdata_q, wstrb_q) & `RHC_REFCONF_WMSK; // R19

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_q          <= `RHC_REFCONF_RST; // R1
            capture_done_q <= 1'b0;
        end else begin
            if (wr_cfg)
                cfg_q <= cfg_new;
            // disarm only when the pending event is cleared and no new one lands
            if (done_clr && !done_set && !(wr_cfg && cfg_new[`RHC_B_HOME_ARM]))
                cfg_q[`RHC_B_HOME_ARM] <= 1'b0; // R10
            if (done_set)
                capture_done_q <= 1'b1; // R10
            else if (done_clr)
                capture_done_q <= 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            actual_position_q  <= 32'h00000000;
            target_position_q  <= 32'h00000000;
            circular_range_q   <= 32'h00000000;
            compare_position_q <= 32'h00000000;
            ramp_restart       <= 1'b0;
        end else begin
            ramp_restart <= zero_now; // R11
            if (wr_act)
                actual_position_q <= byte_merge(actual_position_q, wdata_q, wstrb_q);
            else if (zero_now)
                actual_position_q <= 32'h00000000; // R11
            else if (step_pulse)
                actual_position_q <= step_wrap(actual_position_q, step_dir,
                                               cfg_q[`RHC_B_POS_WRAP],
                                               circular_range_q); // R12
            if (wr_fire && wr_idx == `RHC_IDX_TARGET)
                target_position_q <= byte_merge(target_position_q, wdata_q, wstrb_q);
            if (wr_fire && wr_idx == `RHC_IDX_RANGE)
                circular_range_q <= byte_merge(circular_range_q, wdata_q, wstrb_q);
            if (wr_fire && wr_idx == `RHC_IDX_COMPARE)
                compare_position_q <= byte_merge(compare_position_q, wdata_q, wstrb_q);
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            encoder_position_q <= 32'h00000000;
            latched_position_q <= 32'h00000000;
            encoder_latched_q  <= 32'h00000000;
            home_position_q    <= 32'h00000000;
            home_entry_q       <= 32'h00000000;
            pin_prev_q         <= 6'h00;
            stop_l_act_q       <= 1'b0;
            stop_r_act_q       <= 1'b0;
            home_act_q         <= 1'b0;
        end else begin
            pin_prev_q   <= pin_s;
            stop_l_act_q <= stop_l_act;
            stop_r_act_q <= stop_r_act;
            home_act_q   <= home_act;
            if (enc_step)
                encoder_position_q <= step_wrap(encoder_position_q, enc_up,
                                                cfg_q[`RHC_B_ENC_WRAP],
                                                circular_range_q); // R13
            if (stop_capture) begin
                latched_position_q <= actual_position_q; // R2 R3 R18
                encoder_latched_q  <= encoder_position_q;
            end
            if (h_enter)
                home_entry_q <= actual_position_q;
            if (done_set)
                home_position_q <= home_value; // R10
        end
    end

    // ------------------------------------------------------------
    // compare and goal output
    // ------------------------------------------------------------
    wire [31:0] cmp_src = cfg_q[`RHC_B_CMP_SRC] ? encoder_position_q
                                                : actual_position_q; // R15
    reg  [31:0] cmp_op;
    reg         goal_sel;

    always @* begin
        case (cfg_q[`RHC_F_CMPOP_HI:`RHC_F_CMPOP_LO]) // R16
            2'h0:    cmp_op = compare_position_q;
            2'h1:    cmp_op = home_position_q;
            2'h2:    cmp_op = cfg_q[`RHC_B_CMP_SRC] ? encoder_latched_q
                                                    : latched_position_q;
            default: cmp_op = revolution_count;
        endcase
        case (cfg_q[`RHC_F_GSEL_HI:`RHC_F_GSEL_LO]) // R14
            2'h0:    goal_sel = goal_flag;
            2'h1:    goal_sel = speed_attained_flag;
            2'h2:    goal_sel = encoder_fault_flag;
            default: goal_sel = compare_match_flag;
        endcase
    end

    // goal pin lags its source one clock; a compare source lags two
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            compare_match_flag  <= 1'b0;
            goal_arrival_output <= 1'b0;
        end else begin
            compare_match_flag  <= (cmp_src == cmp_op); // R15 R16
            goal_arrival_output <= goal_sel; // R14
        end
    end
endmodule // rhc_ref_switch

// ===== tb/rhc_ref_switch_properties.sv
// concurrent checks on the reference switch block
`timescale 1ns/1ps
module rhc_ref_checker #(
    parameter ADDR_W = 8
) (
    input wire              clk_sys, rst_n, s_axi_awvalid, s_axi_awready,
    input wire              s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire              goal_arrival_output, ramp_restart, compare_match_flag,
    input wire [31:0]       s_axi_rdata,
    input wire [1:0]        s_axi_rresp,
    input wire [ADDR_W-1:0] s_axi_araddr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
        !s_axi_bvalid && !s_axi_rvalid && !ramp_restart && !compare_match_flag
        && !goal_arrival_output) else $error("reset not clean");
    chk_wr_closed: assert property (s_wr_both |=> !s_axi_awready && !s_axi_wready)
        else $error("write left open");
    chk_b_answer: assert property (s_wr_both |-> ##[1:3] s_axi_bvalid)
        else $error("no write answer");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid ##1 s_axi_awready && s_axi_wready) else $error("write not reopened");
    chk_r_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid ##1 s_axi_arready) else $error("read not reopened");
    chk_bad_read: assert property (s_rd_taken ##0 (s_axi_araddr[7:2] > 6'd9) |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad read answer");
    chk_restart_pulse: assert property (ramp_restart |=> !ramp_restart)
        else $error("restart too long");
endmodule // rhc_ref_checker
bind rhc_ref_switch rhc_ref_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== tb/rhc_far_side.sv
// behavioural stop switches, home sensor and quadrature encoder
`timescale 1ns/1ps
module rhc_far_side (
    input wire clk_sys,
    output reg left_stop_input, right_stop_input, home_reference_input,
    output reg enc_a, enc_b, enc_n
);
    reg [1:0] ph_q;
    initial {left_stop_input, right_stop_input, home_reference_input, enc_a, enc_b, enc_n,
        ph_q} = 8'h00;
    task pins(input [2:0] v);
        @(posedge clk_sys);
        {left_stop_input, right_stop_input, home_reference_input} <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    // gray order keeps one line moving per step
    task quad(input up);
        @(posedge clk_sys);
        ph_q = up ? ph_q + 2'd1 : ph_q - 2'd1;
        {enc_a, enc_b} <= {ph_q[1], ph_q[1] ^ ph_q[0]};
        repeat (3) @(posedge clk_sys);
    endtask
    task index;
        @(posedge clk_sys);
        enc_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        enc_n <= 1'b0;
    endtask
endmodule // rhc_far_side

// ===== tb/rhc_ref_switch_tb.sv
// self-checking bench for the reference switch
`timescale 1ns/1ps
module rhc_ref_switch_tb;
    reg        clk_sys, rst_n, awv, wv, bre, arv, rre, stp_p, stp_d, pmode, spd, efail, seen;
    reg [7:0]  awa, ara;
    reg [31:0] wd, rev, d, m;
    reg [1:0]  r;
    wire       awr, wrdy, bv, arr, rv, goal, rstrt, cm, sl, sr, hr, ea, eb, en;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    integer    n_mismatch, n_compared, cyc, i;
    int        md[6] = '{2, 4, 6, 9, 11, 13};
    rhc_far_side fs (.clk_sys(clk_sys), .left_stop_input(sl), .right_stop_input(sr),
        .home_reference_input(hr), .enc_a(ea), .enc_b(eb), .enc_n(en));
    rhc_ref_switch dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .left_stop_input(sl), .right_stop_input(sr), .home_reference_input(hr),
        .enc_a(ea), .enc_b(eb), .enc_n(en), .step_pulse(stp_p), .step_dir(stp_d),
        .positioning_mode(pmode), .speed_attained_flag(spd), .encoder_fault_flag(efail),
        .revolution_count(rev), .goal_arrival_output(goal), .ramp_restart(rstrt),
        .compare_match_flag(cm));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task summarize;
        if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        n_compared = n_compared + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: %h not %h", $time, g, e);
        end
    endtask
    task chkb(input g, input e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    task cy(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input [7:0] a, input [31:0] v);
        cy(1);
        {awa, wd, awv, wv, bre} <= {a, v, 3'b111};
        do begin
            cy(1);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
    endtask
    task rd(input [7:0] a);
        cy(1);
        {ara, arv, rre} <= {a, 2'b11};
        do begin
            cy(1);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        {d, r} = {rdat, rr};
        rre <= 1'b0;
    endtask
    task rc(input [7:0] a, input [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    task stp(input up);
        cy(1);
        {stp_p, stp_d} <= {1'b1, up};
        cy(1);
        stp_p <= 1'b0;
        cy(2);
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rstrt === 1'b1) seen <= 1'b1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            summarize;
        end
    end
    initial begin
        {awv, wv, bre, arv, rre, stp_p, stp_d, pmode, spd, efail, seen, awa, ara, wd, rev} = '0;
        {rst_n, n_mismatch, n_compared, cyc} = '0;
        cy(10);
        rst_n <= 1'b1;
        rc(8'h04, 32'h0);
        wr(8'h04, 32'hffffffff);
        rc(8'h04, 32'hb3ffffff);
        rd(8'h40);
        chk({30'h0, r}, 32'h2);
        wr(8'h04, 32'h00002008);
        wr(8'h08, 32'h1234);
        fs.pins(3'b010);
        rc(8'h18, 32'h1234);
        wr(8'h04, 32'h00001008);
        wr(8'h08, 32'h55);
        fs.pins(3'b000);
        rc(8'h18, 32'h55);
        wr(8'h08, 32'h77);
        fs.pins(3'b010);
        rc(8'h18, 32'h55);
        foreach (md[i]) begin
            m = md[i];
            fs.pins({2'b01, m > 8});
            wr(8'h08, m);
            wr(8'h04, 32'h00100000 | (m << 16));
            fs.pins({2'b01, m < 9});
            fs.pins({2'b01, m > 8});
            rc(8'h1c, m);
            wr(8'h00, 32'h1);
            rc(8'h04, m << 16);
        end
        wr(8'h08, 32'h42);
        wr(8'h04, 32'h00100000);
        fs.index;
        cy(6);
        rc(8'h1c, 32'h42);
        rd(8'h00);
        chkb(d[0], 1'b1);
        wr(8'h00, 32'h1);
        fs.pins(3'b000);
        wr(8'h08, 32'h99);
        wr(8'h04, 32'h00124004);
        fs.pins(3'b110);
        rc(8'h1c, 32'h99);
        wr(8'h10, 32'h4);
        wr(8'h04, 32'h00400000);
        wr(8'h08, 32'h3);
        stp(1'b1);
        rc(8'h08, 32'hfffffffc);
        stp(1'b0);
        rc(8'h08, 32'h3);
        wr(8'h04, 32'h80000000);
        repeat (4) fs.quad(1'b1);
        rc(8'h20, 32'hfffffffc);
        {spd, efail, rev} <= {2'b11, 32'h10};
        wr(8'h08, 32'h10);
        for (i = 0; i < 4; i++) begin
            wr(8'h04, 32'h30000000 | (i << 23));
            cy(3);
            chkb(goal, i != 0);
        end
        wr(8'h14, 32'h10);
        wr(8'h04, 32'h0);
        cy(3);
        chkb(cm, 1'b1);
        wr(8'h04, 32'h02000000);
        cy(3);
        chkb(cm, 1'b0);
        wr(8'h08, 32'h99);
        wr(8'h04, 32'h10000000);
        cy(3);
        chkb(cm, 1'b1);
        wr(8'h0c, 32'h99);
        pmode <= 1'b1;
        wr(8'h04, 32'h00200000);
        cy(4);
        rc(8'h08, 32'h0);
        chkb(seen, 1'b1);
        summarize;
    end
endmodule // rhc_ref_switch_tb
